// file: hdl/rcr_pkg.sv
// Package for the remote capability register block.
// Holds offsets, field positions, reset values and the carrier structs.
// Assumes the register port delivers 8-bit offsets and byte data.
package rcr_pkg;

    // ************************************************************
    // Register offsets and widths
    // ************************************************************
    localparam int RCR_ADDR_W = 8;
    localparam int RCR_DATA_W = 8;
    localparam logic [7:0] RCR_CAP1_OFFSET = 8'h20;
    localparam logic [7:0] RCR_CAP2_OFFSET = 8'h21;
    localparam logic [7:0] RCR_RESET_VALUE = 8'h00;
    localparam logic [7:0] RCR_READ_UNMAPPED = 8'h00;

    // ************************************************************
    // Field positions in the first capability register
    // ************************************************************
    localparam int RCR_FREEZE_BIT = 7;
    localparam int RCR_MODE0_BIT = 6;
    localparam int RCR_FREQ_BIT = 5;
    localparam int RCR_EQ_BIT = 4;
    localparam int RCR_TWO_LANE_BIT = 3;
    localparam int RCR_ROLE_BIT = 2;

    // Field positions in the second capability register.
    localparam int RCR_MODE_HI_LSB = 0;
    localparam int RCR_MODE_HI_MSB = 1;

    // ************************************************************
    // Fast control channel modes
    // ************************************************************
    typedef enum logic [2:0] {
        RCR_MODE_NORMAL = 3'h0,
        RCR_MODE_FAST_1 = 3'h1,
        RCR_MODE_FAST_2 = 3'h2,
        RCR_MODE_FAST_4 = 3'h3
    } rcr_mode_t;

    // Channel role values.
    localparam logic RCR_ROLE_PRIMARY = 1'b0;
    localparam logic RCR_ROLE_SECONDARY = 1'b1;

    // ************************************************************
    // Carrier structs
    // ************************************************************
    // Capabilities as reported by the remote receiver.
    typedef struct packed {
        logic [2:0] fastCtrlChannelMode;
        logic freqTrainingRequest;
        logic eqTrainingRequest;
        logic twoLaneCapable;
        logic channelRole;
    } rcr_learn_t;

    // One port's stored copy: learned fields plus the freeze bit.
    typedef struct packed {
        logic capabilityFreeze;
        rcr_learn_t fields;
    } rcr_cap_t;

    localparam rcr_cap_t RCR_CAP_RESET = '0;

endpackage : rcr_pkg

// file: hdl/rcr_cap_port.sv
// One port's copy of the remote capability fields.
// Assumes write strobes are already decoded for this port and offset.
`timescale 1ns/1ps
module rcr_cap_port
    import rcr_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Software writes.
    input wire logic wrCap1,
    input wire logic wrCap2,
    input wire logic [RCR_DATA_W-1:0] wrData,
    // Control channel updates.
    input wire logic rxLock,
    input wire logic learnStrobe,
    input wire rcr_learn_t learned,
    // Stored copy.
    output rcr_cap_t cap
);

    rcr_cap_t capQ;
    rcr_cap_t capD;

    // Computes the next copy; a software write wins over a learn.
    always_comb begin
        capD = capQ;
        if (wrCap1) begin
            capD.capabilityFreeze = wrData[RCR_FREEZE_BIT];
            capD.fields.fastCtrlChannelMode[0] =
                wrData[RCR_MODE0_BIT];
            capD.fields.freqTrainingRequest = wrData[RCR_FREQ_BIT];
            capD.fields.eqTrainingRequest = wrData[RCR_EQ_BIT];
            capD.fields.twoLaneCapable = wrData[RCR_TWO_LANE_BIT];
            capD.fields.channelRole = wrData[RCR_ROLE_BIT];
        end
        if (wrCap2) begin
            capD.fields.fastCtrlChannelMode[2:1] =
                wrData[RCR_MODE_HI_MSB:RCR_MODE_HI_LSB];
        end
        // Learning only after lock and never while frozen.
        if (!wrCap1 && !wrCap2 && rxLock && learnStrobe
                && !capQ.capabilityFreeze) begin
            capD.fields = learned;
        end
    end

    // Registers the copy; everything clears to zero.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            capQ <= RCR_CAP_RESET;
        end else begin
            capQ <= capD;
        end
    end

    assign cap = capQ;

endmodule : rcr_cap_port

// file: hdl/rcr_capability_regs.sv
// Remote capability registers for both ports of the bridge.
// Assumes the register port is driven by the serial control bus slave
// in the core_clk domain, and that the port-select bits live outside.
//
// Overview of operation
// - Freeze bit blocks all automatic capability loading.
// - Frozen values are those software last wrote.
// - Bit 6 is mode LSB; upper bits elsewhere.
// - After lock, control channel updates capability fields.
// - Bit 5 set sends frequency training pattern.
// - Bit 4 set sends equalization training pattern.
// - Bit 3 flags two-lane capable receiver.
// - Bit 2: zero primary, one secondary channel; secondaryChannel is only set when bit 3 is also set.
// - Second-port view redirects access to port one.
// - Freeze, mode and eq fields reset zero.
// - Mode decode; single-link devices use normal only.
// - Port view ignored when second bus address on.
`timescale 1ns/1ps
module rcr_capability_regs
    import rcr_pkg::*;
#(
    parameter int NUM_PORTS = 2,
    parameter bit TWO_LINK_DEVICE = 1'b1
) (
    // Clock and reset.
    input wire logic core_clk,
    input wire logic rst_n,
    // Register access from the control bus slave.
    input wire logic [RCR_ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [RCR_DATA_W-1:0] regWdata,
    input wire logic viaSecondAddress,
    output logic [RCR_DATA_W-1:0] regRdata,
    output logic regRdValid,
    // Port-select controls.
    input wire logic secondPortView,
    input wire logic secondPortBusAddressOn,
    // Control channel, one entry per port.
    input wire logic [NUM_PORTS-1:0] rxLock,
    input wire logic [NUM_PORTS-1:0] learnStrobe,
    input wire rcr_learn_t [NUM_PORTS-1:0] learned,
    // Per-port capability outputs to the link logic.
    output logic [NUM_PORTS-1:0] freqTrainingTx,
    output logic [NUM_PORTS-1:0] eqTrainingTx,
    output rcr_mode_t [NUM_PORTS-1:0] fastCtrlChannelMode,
    output logic [NUM_PORTS-1:0] twoLaneCapable,
    output logic [NUM_PORTS-1:0] secondaryChannel,
    output logic [NUM_PORTS-1:0] capabilityFrozen
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The port decode below only knows two copies, port zero and one.
    if (NUM_PORTS != 2) begin : gNumPortsCheck
        $error("rcr_capability_regs serves exactly two ports");
    end

    // ************************************************************
    // Port selection and decode
    // ************************************************************
    logic portOneSel;
    logic hitCap1;
    logic hitCap2;
    rcr_cap_t cap [NUM_PORTS];

    // With the second address enabled, an access through it means port one;
    // otherwise the view bit picks the port.
    always_comb begin
        if (secondPortBusAddressOn) begin
            portOneSel = viaSecondAddress;
        end else begin
            portOneSel = secondPortView;
        end
        hitCap1 = (regAddr == RCR_CAP1_OFFSET);
        hitCap2 = (regAddr == RCR_CAP2_OFFSET);
    end

    // ************************************************************
    // Per-port storage
    // ************************************************************
    for (genvar p = 0; p < NUM_PORTS; p++) begin : gPort
        logic selThis;
        assign selThis = (portOneSel == (p == 1));

        rcr_cap_port uCapPort (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .wrCap1(regWrite && hitCap1 && selThis),
            .wrCap2(regWrite && hitCap2 && selThis),
            .wrData(regWdata),
            .rxLock(rxLock[p]),
            .learnStrobe(learnStrobe[p]),
            .learned(learned[p]),
            .cap(cap[p])
        );
    end

    // ************************************************************
    // Read path
    // ************************************************************
    // The read byte is held between reads so software sees a stable value.
    rcr_cap_t readCap;
    logic [RCR_DATA_W-1:0] regRdataQ;
    logic [RCR_DATA_W-1:0] regRdataD;
    logic regRdValidQ;
    logic regRdValidD;

    // Builds the read byte from the selected port's copy.
    always_comb begin
        readCap = portOneSel ? cap[1] : cap[0];
        regRdataD = regRdataQ;
        regRdValidD = regRead;
        if (regRead) begin
            regRdataD = RCR_READ_UNMAPPED;
            if (hitCap1) begin
                regRdataD[RCR_FREEZE_BIT] = readCap.capabilityFreeze;
                regRdataD[RCR_MODE0_BIT] =
                    readCap.fields.fastCtrlChannelMode[0];
                regRdataD[RCR_FREQ_BIT] = readCap.fields.freqTrainingRequest;
                regRdataD[RCR_EQ_BIT] = readCap.fields.eqTrainingRequest;
                regRdataD[RCR_TWO_LANE_BIT] = readCap.fields.twoLaneCapable;
                regRdataD[RCR_ROLE_BIT] = readCap.fields.channelRole;
            end else if (hitCap2) begin
                regRdataD[RCR_MODE_HI_MSB:RCR_MODE_HI_LSB] =
                    readCap.fields.fastCtrlChannelMode[2:1];
            end
        end
    end

    // Registers the read answer one cycle after the request.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            regRdataQ <= RCR_RESET_VALUE;
            regRdValidQ <= 1'b0;
        end else begin
            regRdataQ <= regRdataD;
            regRdValidQ <= regRdValidD;
        end
    end

    // The read answer leaves straight from its flops.
    assign regRdata = regRdataQ;
    assign regRdValid = regRdValidQ;

    // ************************************************************
    // Capability outputs to the link logic
    // ************************************************************
    logic [NUM_PORTS-1:0] freqQ;
    logic [NUM_PORTS-1:0] freqD;
    logic [NUM_PORTS-1:0] eqQ;
    logic [NUM_PORTS-1:0] eqD;
    rcr_mode_t [NUM_PORTS-1:0] modeQ;
    rcr_mode_t [NUM_PORTS-1:0] modeD;
    logic [NUM_PORTS-1:0] twoLaneQ;
    logic [NUM_PORTS-1:0] twoLaneD;
    logic [NUM_PORTS-1:0] secondaryQ;
    logic [NUM_PORTS-1:0] secondaryD;
    logic [NUM_PORTS-1:0] frozenQ;
    logic [NUM_PORTS-1:0] frozenD;

    // Derives the link controls; whether learned or written, the stored
    // copy is what the link uses, so frozen values rule when frozen.
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            freqD[p] = cap[p].fields.freqTrainingRequest;
            eqD[p] = cap[p].fields.eqTrainingRequest;
            twoLaneD[p] = cap[p].fields.twoLaneCapable;
            // Role only means something for a two-lane receiver.
            secondaryD[p] = cap[p].fields.twoLaneCapable
                && (cap[p].fields.channelRole
                    == RCR_ROLE_SECONDARY);
            frozenD[p] = cap[p].capabilityFreeze;
            // Reserved codes and single-link builds fall back to normal.
            case (cap[p].fields.fastCtrlChannelMode)
                RCR_MODE_FAST_1,
                RCR_MODE_FAST_2,
                RCR_MODE_FAST_4: begin
                    modeD[p] = TWO_LINK_DEVICE ?
                        rcr_mode_t'(cap[p].fields.fastCtrlChannelMode)
                        : RCR_MODE_NORMAL;
                end
                default: begin
                    modeD[p] = RCR_MODE_NORMAL;
                end
            endcase
        end
    end

    // Registers the link controls so every output comes from a flop.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            freqQ <= '0;
            eqQ <= '0;
            modeQ <= '{default: RCR_MODE_NORMAL};
            twoLaneQ <= '0;
            secondaryQ <= '0;
            frozenQ <= '0;
        end else begin
            freqQ <= freqD;
            eqQ <= eqD;
            modeQ <= modeD;
            twoLaneQ <= twoLaneD;
            secondaryQ <= secondaryD;
            frozenQ <= frozenD;
        end
    end

    // The link controls leave straight from their flops.
    assign freqTrainingTx = freqQ;
    assign eqTrainingTx = eqQ;
    assign fastCtrlChannelMode = modeQ;
    assign twoLaneCapable = twoLaneQ;
    assign secondaryChannel = secondaryQ;
    assign capabilityFrozen = frozenQ;

endmodule : rcr_capability_regs

// file: test/rcr_remote_rx_model.sv
// Model of the remote receivers on both control channels.
// Assumes the bench commands lock per port and the clock is core_clk.
`timescale 1ns/1ps
module rcr_remote_rx_model
    import rcr_pkg::*;
(
    // Clock, reset and lock command.
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] lockOn,
    // Control channel toward the block.
    output logic [1:0] rxLock,
    output logic [1:0] learnStrobe,
    output rcr_learn_t [1:0] learned
);
    int seed = 38825;
    initial begin
        rxLock = 2'h0;
        learnStrobe = 2'h0;
        learned = '0;
    end
    // Reports lock as commanded and sends random learn strobes from reset release, locked or not; data changes every cycle.
    always @(negedge core_clk) begin
        rxLock <= rst_n ? lockOn : 2'h0;
        learnStrobe <= rst_n ? 2'($random(seed)) : 2'h0;
        learned <= 14'($random(seed));
    end
endmodule : rcr_remote_rx_model

// file: test/rcr_capability_regs_checker.sv
// Port-level assertions for the remote capability registers.
// Assumes it is bound into rcr_capability_regs of the two-port build.
`timescale 1ns/1ps
module rcr_capability_regs_checker
    import rcr_pkg::*;
#(
    parameter int NUM_PORTS = 2
) (
    // Clock, reset and register port.
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [RCR_ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [RCR_DATA_W-1:0] regWdata,
    input wire logic viaSecondAddress,
    input wire logic [RCR_DATA_W-1:0] regRdata,
    input wire logic regRdValid,
    input wire logic secondPortView,
    input wire logic secondPortBusAddressOn,
    // Control channel and capability outputs.
    input wire logic [NUM_PORTS-1:0] rxLock,
    input wire logic [NUM_PORTS-1:0] learnStrobe,
    input wire rcr_learn_t [NUM_PORTS-1:0] learned,
    input wire logic [NUM_PORTS-1:0] freqTrainingTx,
    input wire logic [NUM_PORTS-1:0] eqTrainingTx,
    input wire rcr_mode_t [NUM_PORTS-1:0] fastCtrlChannelMode,
    input wire logic [NUM_PORTS-1:0] twoLaneCapable,
    input wire logic [NUM_PORTS-1:0] secondaryChannel,
    input wire logic [NUM_PORTS-1:0] capabilityFrozen
);
    // ********************
    // Assertions
    // ********************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    logic sel1;
    // Port chosen by the access, as the select bits route it.
    assign sel1 = secondPortBusAddressOn ? viaSecondAddress : secondPortView;
    // Learn on port 0 while unfrozen and with no write nearby.
    sequence s_learn0;
        learnStrobe[0] && rxLock[0] && !regWrite && !$past(regWrite)
            && !capabilityFrozen[0];
    endsequence
    // Port 0 stays frozen over two quiet cycles.
    sequence s_frozen0;
        !$past(regWrite) && !regWrite && capabilityFrozen[0]
            ##1 capabilityFrozen[0];
    endsequence
    a_read_answer: assert property (regRead |=> regRdValid)
        else $error("read strobe not answered");
    a_unmapped_zero: assert property (regRead && regAddr != RCR_CAP1_OFFSET
        && regAddr != RCR_CAP2_OFFSET |=> regRdata == RCR_READ_UNMAPPED)
        else $error("unmapped read not zero");
    a_learn_loads: assert property (s_learn0 |-> ##2
        {freqTrainingTx[0], eqTrainingTx[0], twoLaneCapable[0]}
        == $past(learned[0][3:1], 2)) else $error("learn not applied");
    a_freeze_holds: assert property (s_frozen0 |=>
        $stable({freqTrainingTx[0], eqTrainingTx[0], twoLaneCapable[0]}))
        else $error("frozen fields changed");
    a_write_port0: assert property (regWrite && !sel1
        && regAddr == RCR_CAP1_OFFSET |-> ##2 {capabilityFrozen[0],
        freqTrainingTx[0], eqTrainingTx[0]} == $past({regWdata[7],
        regWdata[5:4]}, 2)) else $error("port 0 write lost");
    a_write_port1: assert property (regWrite && sel1
        && regAddr == RCR_CAP1_OFFSET |-> ##2 $stable(capabilityFrozen[0])
        && capabilityFrozen[1] == $past(regWdata[7], 2))
        else $error("port 1 write misrouted");
    a_role_gate: assert property (
        secondaryChannel[1] |-> twoLaneCapable[1])
        else $error("role without two lanes");
    a_reset_clear: assert property (disable iff (1'b0) !rst_n |=>
        ~|{capabilityFrozen, eqTrainingTx, fastCtrlChannelMode, regRdValid})
        else $error("reset did not clear");
endmodule : rcr_capability_regs_checker

// file: test/remote_capability_register_test.sv
// Self-checking bench for the remote capability registers.
// Assumes the two-port build, a 125 MHz clock and the receiver model.
`timescale 1ns/1ps
module remote_capability_register_test
    import rcr_pkg::*;
();
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic viaSecondAddress = 1'b0;
    logic secondPortView = 1'b0;
    logic secondPortBusAddressOn = 1'b0;
    logic [1:0] lockOn = 2'h0;
    logic [1:0] rxLock, learnStrobe, freqTrainingTx, eqTrainingTx;
    logic [1:0] twoLaneCapable, secondaryChannel, capabilityFrozen;
    rcr_learn_t [1:0] learned;
    rcr_mode_t [1:0] fastCtrlChannelMode;
    logic [7:0] regRdata, expRd;
    logic regRdValid, expValid = 1'b0, hit;
    rcr_cap_t st [2], ou [2];
    int n_mismatch = 0, checks = 0, cyc = 0, seed = 38825;
    rcr_capability_regs uut (.*);
    rcr_remote_rx_model remote (.*);
    initial forever #4 core_clk = ~core_clk;
    // ********************
    // Expectation helpers
    // ********************
    function automatic logic port_sel();
        return secondPortBusAddressOn ? viaSecondAddress : secondPortView;
    endfunction : port_sel
    // Byte seen by software at an offset.
    function automatic logic [7:0] rd_byte(rcr_cap_t c, logic [7:0] a);
        if (a == RCR_CAP1_OFFSET)
            return {c.capabilityFreeze, c.fields[4:0], 2'b00};
        if (a == RCR_CAP2_OFFSET)
            return {6'h00, c.fields.fastCtrlChannelMode[2:1]};
        return RCR_READ_UNMAPPED;
    endfunction : rd_byte
    // Outputs as {freq, eq, twoLane, secondary, frozen, mode}.
    function automatic logic [7:0] out_vec(rcr_cap_t c);
        logic [2:0] m;
        m = c.fields.fastCtrlChannelMode;
        return {c.fields[3:1], c.fields[1] & c.fields[0],
            c.capabilityFreeze, m > 3'h3 ? 3'h0 : m};
    endfunction : out_vec
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test
    task automatic drive(input logic w, r, input logic [7:0] a, d);
        @(negedge core_clk);
        regWrite = w;
        regRead = r;
        regAddr = a;
        regWdata = d;
    endtask : drive
    // Reference copy per port; a write beats a same-cycle learn.
    always @(posedge core_clk) begin
        expValid = rst_n && regRead;
        if (regRead)
            expRd = rd_byte(st[port_sel()], regAddr);
        hit = regAddr == RCR_CAP1_OFFSET || regAddr == RCR_CAP2_OFFSET;
        for (int p = 0; p < 2; p++) begin
            ou[p] = rst_n ? st[p] : RCR_CAP_RESET;
            if (!rst_n)
                st[p] = RCR_CAP_RESET;
            else if (regWrite && hit && port_sel() == p[0])
                st[p] = regAddr == RCR_CAP1_OFFSET ? {regWdata[7],
                    st[p].fields.fastCtrlChannelMode[2:1], regWdata[6:2]}
                    : {st[p][7], regWdata[1:0], st[p][4:0]};
            else if (learnStrobe[p] && rxLock[p] && !st[p].capabilityFreeze)
                st[p].fields = learned[p];
        end
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // Compares the capability outputs and read valid every cycle, read data only after a read.
    always @(negedge core_clk) begin
        for (int p = 0; p < 2; p++)
            check({freqTrainingTx[p], eqTrainingTx[p], twoLaneCapable[p],
                secondaryChannel[p], capabilityFrozen[p],
                fastCtrlChannelMode[p]}, out_vec(ou[p]));
        check({7'h00, regRdValid}, {7'h00, expValid});
        if (expValid)
            check(regRdata, expRd);
    end
    // Corner cases first, then random traffic with a mid-run reset.
    initial begin
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        drive(1'b0, 1'b1, RCR_CAP1_OFFSET, 8'h00);
        drive(1'b1, 1'b1, 8'h1F, 8'hFF);
        drive(1'b1, 1'b0, RCR_CAP1_OFFSET, 8'hF4);
        drive(1'b1, 1'b1, RCR_CAP2_OFFSET, 8'hFF);
        lockOn = 2'h3;
        for (int i = 0; i < 3000; i++) begin
            drive(rst_n && 2'($random(seed)) == 2'h0, rst_n && 1'($random(seed)),
                3'($random(seed)) == 3'h0 ? 8'($random(seed))
                : RCR_CAP1_OFFSET + 8'(1'($random(seed))), 8'($random(seed)));
            secondPortView = 1'($random(seed));
            secondPortBusAddressOn = 2'($random(seed)) == 2'h0;
            viaSecondAddress = 1'($random(seed));
            if (6'($random(seed)) == 6'h00)
                lockOn = 2'($random(seed));
            rst_n = !(i inside {[1500:1519]});
        end
        drive(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (3) @(negedge core_clk);
        finish_test();
    end
endmodule : remote_capability_register_test

bind rcr_capability_regs rcr_capability_regs_checker #(
    .NUM_PORTS(NUM_PORTS)
) chk (.*);
